// ### core/ebd_decoder.sv
// Instruction decoder with cycle-count and rotate-through-carry logic.
// Assumes a word is offered with i_word_valid when o_ready is high, and that
// the data path supplies the file-register read value and pointer targets.
// Every output comes straight from a flip-flop; the skip condition and the
// pointer targets must be settled in the clock in which the word is taken.
`timescale 1ns/100ps
`include "ebd_defs.svh"
module ebd_decoder #(
    parameter int WORD_W = `EBD_WORD_W
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // Fetch side.
    input  wire logic                i_word_valid,
    input  wire logic [13:0]         i_word,
    // Data path side.
    input  wire logic                i_skip_taken,
    input  wire logic [1:0]          i_ptr_in_prog,
    input  wire logic [7:0]          i_file_rd,
    input  wire logic                i_carry,
    // Decoded instruction and its timing.
    output ebd_pkg::ebd_dec_type     o_dec,
    output logic                     o_ready,
    output logic                     o_icyc,
    output logic [1:0]               o_ncyc,
    // Read-modify-write strobes and the rotate result.
    output logic                     o_file_rd_en,
    output logic                     o_file_wr_en,
    output logic                     o_acc_wr_en,
    output logic [7:0]               o_result,
    output logic                     o_carry_wr,
    output logic                     o_carry
);
    // ------------------------------------------------------------------
    // Timing of one instruction
    // ------------------------------------------------------------------
    // Each instruction cycle is four clocks, numbered by phase_r from 0.
    // A word is taken at the edge that ends phase 3 while o_ready is high;
    // o_dec and o_ncyc show it from the next clock on and hold until the
    // next take.
    // In the first instruction cycle the read strobe follows phase 0, the
    // rotate result phase 1 and the write strobes phase 2, so even a
    // write-only operand is read before it is written.
    // A word offered while o_ready is low is ignored without notice; the
    // fetch side keeps it up until it is taken.
    // Multi-cycle instructions hold o_ready low until their last cycle, so
    // the next word is taken exactly when this one finishes.
    initial begin
        if (WORD_W != `EBD_WORD_W) begin
            $error("Word width must be 14.");
        end
        if (`EBD_PHASES != 4) begin
            $error("The phase counter serves four phases only.");
        end
    end

    // ------------------------------------------------------------------
    // Instruction cycle divider
    // ------------------------------------------------------------------
    logic [1:0] phase_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    wire logic icyc_end = (phase_r == `EBD_PH_LAST);
    // Read, modify and write fall in fixed phases of the first instruction cycle.
    wire logic ph_read  = (phase_r == `EBD_PH_READ);
    wire logic ph_mod   = (phase_r == `EBD_PH_MOD);
    wire logic ph_write = (phase_r == `EBD_PH_WRITE);

    // ------------------------------------------------------------------
    // Format matching
    // ------------------------------------------------------------------
    // The short formats share their leading zeros, so each match is named
    // here and the decode below tries the longest opcode field first.
    wire logic m_oponly = (i_word[13:4] == `EBD_M_OPONLY);
    wire logic m_lit5   = (i_word[13:5] == `EBD_M_LIT5);
    wire logic m_ptrinc = (i_word[13:7] == `EBD_M_PTRINC);
    wire logic m_byte   = (i_word[13:12] == `EBD_M_BYTE);
    wire logic m_bit    = (i_word[13:12] == `EBD_M_BIT);
    wire logic m_jump   = (i_word[13:12] == `EBD_M_JUMP);
    wire logic m_lit9   = (i_word[13:9] == `EBD_M_LIT9);
    wire logic m_lit7   = (i_word[13:7] == `EBD_M_LIT7);
    wire logic m_ptrofs = (i_word[13:7] == `EBD_M_PTROFS);

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    ebd_pkg::ebd_dec_type dec_nxt;
    logic [1:0]           ncyc_nxt;

    always_comb begin
        dec_nxt           = '0;
        dec_nxt.faddr     = i_word[6:0];
        dec_nxt.dest_file = i_word[7];
        dec_nxt.bitnum    = i_word[9:7];
        // Opcode only: the whole word names the operation.
        if (m_oponly) begin
            dec_nxt.fmt    = ebd_pkg::EBD_FMT_OPONLY;
            dec_nxt.opcode = i_word;
        // Short literal: nine opcode bits, five value bits.
        end else if (m_lit5) begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_LIT5;
            dec_nxt.opcode  = {5'h00, i_word[13:5]};
            dec_nxt.literal = {6'h00, i_word[4:0]};
        // Pointer step: pointer number and step mode.
        end else if (m_ptrinc) begin
            dec_nxt.fmt      = ebd_pkg::EBD_FMT_PTRINC;
            dec_nxt.opcode   = {7'h00, i_word[13:7]};
            dec_nxt.ptr_sel  = i_word[2];
            dec_nxt.ptr_mode = i_word[1:0];
        // Byte operation on a file register.
        end else if (m_byte) begin
            dec_nxt.fmt       = ebd_pkg::EBD_FMT_BYTE;
            dec_nxt.opcode    = {8'h00, i_word[13:8]};
            dec_nxt.uses_file = 1'b1;
            dec_nxt.is_rot    = (i_word[11:8] == `EBD_OP_ROTATE);
        // Bit operation on a file register.
        end else if (m_bit) begin
            dec_nxt.fmt       = ebd_pkg::EBD_FMT_BIT;
            dec_nxt.opcode    = {10'h000, i_word[13:10]};
            dec_nxt.uses_file = 1'b1;
        // Absolute jumps with an eleven-bit target.
        end else if (m_jump) begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_LIT11;
            dec_nxt.opcode  = {11'h000, i_word[13:11]};
            dec_nxt.literal = i_word[10:0];
        // Relative jump with a nine-bit offset.
        end else if (m_lit9) begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_LIT9;
            dec_nxt.opcode  = {9'h000, i_word[13:9]};
            dec_nxt.literal = {2'h0, i_word[8:0]};
        // Page load with a seven-bit value.
        end else if (m_lit7) begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_LIT7;
            dec_nxt.opcode  = {7'h00, i_word[13:7]};
            dec_nxt.literal = {4'h0, i_word[6:0]};
        // Pointer offset: pointer number and six-bit offset.
        end else if (m_ptrofs) begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_PTROFS;
            dec_nxt.opcode  = {7'h00, i_word[13:7]};
            dec_nxt.ptr_sel = i_word[6];
            dec_nxt.literal = {5'h00, i_word[5:0]};
        // Everything else carries an eight-bit constant.
        end else begin
            dec_nxt.fmt     = ebd_pkg::EBD_FMT_LIT8;
            dec_nxt.opcode  = {8'h00, i_word[13:8]};
            dec_nxt.literal = {3'h0, i_word[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // Cycle count
    // ------------------------------------------------------------------
    // A skip that is not taken adds no cycle to its instruction; the
    // data path settles i_skip_taken before the take.
    // Returns from subroutines and interrupts.
    wire logic exit_op = (i_word == `EBD_OP_RETURN) || (i_word == `EBD_OP_IRQ_EXIT) ||
                         (i_word[13:8] == `EBD_OP_LIT_EXIT);
    // Subroutine jumps, direct and through the accumulator.
    wire logic call_op = (i_word == `EBD_OP_ACC_CALL) || (m_jump && !i_word[11]);
    // Other changes of program flow.
    wire logic flow_op = (i_word == `EBD_OP_ACC_JUMP) || (m_jump && i_word[11]) || m_lit9;
    // Skipping byte and bit operations.
    wire logic skip_op = (m_byte && (i_word[11:8] == `EBD_OP_DEC_SKIP ||
                                     i_word[11:8] == `EBD_OP_INC_SKIP)) ||
                         (m_bit && i_word[11]);
    // File access through a slot whose pointer addresses program memory.
    wire logic indirect = dec_nxt.uses_file &&
                          ((i_word[6:0] == `EBD_SLOT0 && i_ptr_in_prog[0]) ||
                           (i_word[6:0] == `EBD_SLOT1 && i_ptr_in_prog[1]));

    always_comb begin
        ncyc_nxt = `EBD_NCYC_ONE;
        if (exit_op || call_op || flow_op || (skip_op && i_skip_taken)) begin
            ncyc_nxt = `EBD_NCYC_TWO;
        end
        if (indirect) begin
            ncyc_nxt = ncyc_nxt + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    ebd_pkg::ebd_state_type state_r;
    logic [1:0]             left_r;
    wire logic take = icyc_end && i_word_valid && (state_r == ebd_pkg::EBD_ST_IDLE ||
                                                   left_r == 2'h1);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ebd_pkg::EBD_ST_IDLE;
            left_r  <= 2'h0;
        end else if (icyc_end) begin
            case (state_r)
                ebd_pkg::EBD_ST_IDLE: begin
                    if (take) begin
                        state_r <= ebd_pkg::EBD_ST_EXEC;
                        left_r  <= ncyc_nxt;
                    end
                end
                ebd_pkg::EBD_ST_EXEC: begin
                    if (take) begin
                        left_r <= ncyc_nxt;
                    end else if (left_r == 2'h1) begin
                        state_r <= ebd_pkg::EBD_ST_IDLE;
                        left_r  <= 2'h0;
                    end else begin
                        left_r <= left_r - 2'h1;
                    end
                end
                default: begin
                    state_r <= ebd_pkg::EBD_ST_IDLE;
                    left_r  <= 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dec  <= '0;
            o_ncyc <= 2'h0;
        end else if (take) begin
            o_dec  <= dec_nxt;
            o_ncyc <= ncyc_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_icyc <= 1'b0;
        end else begin
            o_icyc <= icyc_end;
        end
    end

    // Ready is raised one clock ahead so that it stands during phase 3,
    // the phase whose closing edge takes the word.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= ph_write && (state_r == ebd_pkg::EBD_ST_IDLE ||
                                   left_r == 2'h1);
        end
    end

    // ------------------------------------------------------------------
    // Read-modify-write and rotate
    // ------------------------------------------------------------------
    // Read strobe after phase 0 and write after phase 2 of the first cycle, so
    // even a write-only operand is read first.
    wire logic first_cyc = (state_r == ebd_pkg::EBD_ST_EXEC) && (left_r == o_ncyc);
    wire logic rot_cyc   = first_cyc && o_dec.is_rot;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_file_rd_en <= 1'b0;
        end else begin
            o_file_rd_en <= first_cyc && o_dec.uses_file && ph_read;
        end
    end

    // Only the rotate writes back from this block; other byte operations
    // get the read strobe alone.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_file_wr_en <= 1'b0;
            o_acc_wr_en  <= 1'b0;
            o_carry_wr   <= 1'b0;
        end else begin
            o_file_wr_en <= rot_cyc && o_dec.dest_file && ph_write;
            o_acc_wr_en  <= rot_cyc && !o_dec.dest_file && ph_write;
            o_carry_wr   <= rot_cyc && ph_write;
        end
    end

    // The result is formed one phase after the read strobe, once the data
    // path has had a clock to put the operand on i_file_rd.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_result <= 8'h00;
            o_carry  <= 1'b0;
        end else if (rot_cyc && ph_mod) begin
            o_result <= {i_carry, i_file_rd[7:1]};
            o_carry  <= i_file_rd[0];
        end
    end
endmodule

// ### dv/ebd_decoder_checker.sv
// Port assertions for the instruction decoder.
// Assumes it is bound onto every ebd_decoder instance.
`timescale 1ns/100ps
module ebd_decoder_checker #(
    parameter int WORD_W = 14
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst,
    input wire logic                 i_word_valid,
    input wire logic [13:0]          i_word,
    input wire ebd_pkg::ebd_dec_type o_dec,
    input wire logic                 o_ready,
    input wire logic [1:0]           o_ncyc,
    input wire logic                 o_file_rd_en,
    input wire logic                 o_file_wr_en,
    input wire logic                 o_acc_wr_en,
    input wire logic                 o_carry_wr
);
    wire take    = o_ready & i_word_valid;
    wire byte_op = take && i_word[13:12] == 2'h0 && i_word[11:8] != 4'h0;
    wire only_op = take && i_word[13:2] == 12'h002;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_ready_gap: assert property (o_ready |=> !o_ready [*3])
        else $error("ready came back too soon");
    a_byte_fields: assert property (byte_op |=>
        o_dec.faddr == $past(i_word[6:0]) && o_dec.dest_file == $past(i_word[7]))
        else $error("byte fields wrong");
    a_bit_fields: assert property (take && i_word[13:12] == 2'h1 |=>
        o_dec.bitnum == $past(i_word[9:7]) && o_dec.faddr == $past(i_word[6:0]))
        else $error("bit fields wrong");
    a_jump_target: assert property (take && i_word[13:12] == 2'h2 |=>
        o_dec.literal == $past(i_word[10:0]) && o_ncyc == 2'h2)
        else $error("jump decode wrong");
    a_dec_hold: assert property (!take |=> $stable(o_dec))
        else $error("decode changed without a take");
    a_rmw_order: assert property (o_file_wr_en |->
        $past(o_file_rd_en, 2) || $past(o_file_rd_en, 3))
        else $error("write without earlier read");
    a_rot_dest: assert property (o_file_wr_en || o_acc_wr_en |->
        o_carry_wr && o_dec.is_rot && (o_file_wr_en != o_acc_wr_en))
        else $error("rotate writeback wrong");
    a_opcode_only: assert property (only_op |=>
        o_dec.opcode == $past(i_word) && o_ncyc == 2'h2)
        else $error("opcode-only decode wrong");
endmodule
bind ebd_decoder ebd_decoder_checker #(.WORD_W(WORD_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_word_valid(i_word_valid), .i_word(i_word), .o_dec(o_dec), .o_ready(o_ready),
    .o_ncyc(o_ncyc), .o_file_rd_en(o_file_rd_en), .o_file_wr_en(o_file_wr_en),
    .o_acc_wr_en(o_acc_wr_en), .o_carry_wr(o_carry_wr));

// ### dv/test_eight_bit_core_instruction_decode.sv
// Self-checking bench for the instruction decoder.
// Assumes the hand-over timing; inputs change on falling edges.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module test_eight_bit_core_instruction_decode;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_word_valid = 1'b0, i_skip_taken = 1'b0;
    logic        i_carry = 1'b0, rd_s, fw_s, aw_s, cy_s;
    logic [13:0] i_word = 14'h0000;
    logic [1:0]  i_ptr_in_prog = 2'h0, o_ncyc, n_s;
    logic [7:0]  i_file_rd = 8'h00, o_result, res_s;
    logic        o_ready, o_icyc, o_file_rd_en, o_file_wr_en, o_acc_wr_en, o_carry_wr, o_carry;
    int          error_cnt = 0, n_compared = 0;
    ebd_pkg::ebd_dec_type o_dec;
    ebd_decoder u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_word_valid(i_word_valid),
        .i_word(i_word), .i_skip_taken(i_skip_taken), .i_ptr_in_prog(i_ptr_in_prog),
        .i_file_rd(i_file_rd), .i_carry(i_carry), .o_dec(o_dec), .o_ready(o_ready),
        .o_icyc(o_icyc), .o_ncyc(o_ncyc), .o_file_rd_en(o_file_rd_en),
        .o_file_wr_en(o_file_wr_en), .o_acc_wr_en(o_acc_wr_en), .o_result(o_result),
        .o_carry_wr(o_carry_wr), .o_carry(o_carry));
    initial forever #5 i_clk = ~i_clk;
    // The word is scrambled after the take so a late capture cannot pass.
    task automatic issue(input logic [13:0] w, input int n);
        int gap = -1;
        int ic = 0;
        {rd_s, fw_s, aw_s, cy_s, res_s} = '0;
        for (int k = 0; k < 20 && o_ready !== 1'b1; k++) @(negedge i_clk);
        i_word_valid = 1'b1;
        i_word = w;
        @(negedge i_clk);
        i_word_valid = 1'b0;
        i_word = ~w;
        n_s = o_ncyc;
        for (int k = 0; k <= 4 * n; k++) begin
            rd_s |= o_file_rd_en;
            fw_s |= o_file_wr_en;
            aw_s |= o_acc_wr_en;
            ic += o_icyc;
            if (o_carry_wr === 1'b1) {cy_s, res_s} = {o_carry, o_result};
            if (o_ready === 1'b1 && gap < 0) gap = k;
            @(negedge i_clk);
        end
        `CHK(n_s, 2'(n))
        `CHK(gap, 4 * n - 1)
        `CHK(ic, n + 1)
    endtask
    task t_fields;
        issue(14'h07ff, 1);
        `CHK(o_dec.faddr, 7'h7f)
        `CHK(o_dec.dest_file, 1'b1)
        issue(14'h0702, 1);
        `CHK(o_dec.dest_file, 1'b0)
        issue(14'h13d5, 1);
        `CHK(o_dec.fmt, ebd_pkg::EBD_FMT_BIT)
    endtask
    task t_skips;
        logic [13:0] ops [4] = '{14'h1c02, 14'h1802, 14'h0b82, 14'h0f82};
        foreach (ops[i]) begin
            i_skip_taken = 1'b1;
            issue(ops[i], 2);
            i_skip_taken = 1'b0;
            issue(ops[i], 1);
        end
    endtask
    task t_flow;
        logic [13:0] ops [4] = '{14'h0008, 14'h0009, 14'h000a, 14'h000b};
        issue(14'h2fff, 2);
        `CHK(o_dec.literal, 11'h7ff)
        issue(14'h2123, 2);
        issue(14'h33ff, 2);
        `CHK(o_dec.literal, 11'h1ff)
        issue(14'h34a5, 2);
        foreach (ops[i]) begin
            issue(ops[i], 2);
            `CHK(o_dec.opcode, ops[i])
        end
    endtask
    task t_lits;
        issue(14'h30a5, 1);
        `CHK(o_dec.literal, 11'h0a5)
        issue(14'h31ff, 1);
        `CHK(o_dec.literal, 11'h07f)
        issue(14'h003f, 1);
        `CHK(o_dec.literal, 11'h01f)
        issue(14'h317f, 1);
        `CHK({o_dec.ptr_sel, o_dec.literal}, 12'h83f)
        for (int m = 0; m < 4; m++) begin
            issue(14'h0014 | 14'(m), 1);
            `CHK({o_dec.ptr_sel, o_dec.ptr_mode}, 3'(4 + m))
        end
    endtask
    task t_indirect;
        i_ptr_in_prog = 2'h2;
        issue(14'h0781, 2);
        issue(14'h0780, 1);
        i_ptr_in_prog = 2'h1;
        issue(14'h0780, 2);
        issue(14'h0781, 1);
        i_ptr_in_prog = 2'h0;
    endtask
    task t_rotate;
        i_file_rd = 8'h81;
        issue(14'h0cff, 1);
        `CHK({rd_s, fw_s, aw_s}, 3'h6)
        `CHK({cy_s, res_s}, 9'h140)
        i_file_rd = 8'h02;
        i_carry = 1'b1;
        issue(14'h0c05, 1);
        `CHK({rd_s, fw_s, aw_s}, 3'h5)
        `CHK({cy_s, res_s}, 9'h081)
    endtask
    task print_verdict;
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        t_fields();
        t_skips();
        t_flow();
        t_lits();
        t_indirect();
        t_rotate();
        print_verdict();
    end
    // The tests need well under ten thousand cycles, so this leaves ample margin.
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule

// ### shared/ebd_defs.svh
// Constants for the instruction decoder: phases, format match values, opcodes, cycle counts.
// Assumes it is included once per compilation unit by bare name.
// How it works
// - One 14-bit word holds opcode and operands.
// - Ordinary instructions take one instruction cycle.
// - Both subroutine jumps take two cycles.
// - Subroutine, literal and interrupt exits take two.
// - Jumps, branches and taken skips take two.
// - Indirect access to program memory adds one.
// - Instruction cycle is four oscillator cycles.
// - File operands are read, modified, then stored.
// - Destination bit: 0 accumulator, 1 file register.
// - File address spans 0x00 to 0x7F.
// - Byte format: opcode, destination, 7-bit address.
// - Bit format: opcode, 3-bit number, address.
// - Literal format: opcode and 8-bit constant.
// - Jump formats: opcode 13-11, target 10-0.
// - Page load: opcode 13-7, value 6-0.
// - Short literal: opcode 13-5, value 4-0.
// - Relative jump: opcode 13-9, offset 8-0.
// - Pointer offset: opcode, pointer select, 6-bit offset.
// - Pointer step: opcode, pointer select, 2-bit mode.
// - Pointer select names pointer 0 or 1.
// - Rotate right through carry, only carry changes.
`ifndef EBD_DEFS_SVH
`define EBD_DEFS_SVH
`define EBD_WORD_W      14
`define EBD_PHASES      4
`define EBD_PH_READ     2'h0
`define EBD_PH_MOD      2'h1
`define EBD_PH_WRITE    2'h2
`define EBD_PH_LAST     2'h3
`define EBD_F_MAX       7'h7f
`define EBD_NCYC_ONE    2'h1
`define EBD_NCYC_TWO    2'h2
// Match values of the leading opcode bits of each format but the eight-bit literal.
`define EBD_M_OPONLY    10'h000
`define EBD_M_LIT5      9'h001
`define EBD_M_PTRINC    7'h00
`define EBD_M_BYTE      2'h0
`define EBD_M_BIT       2'h1
`define EBD_M_JUMP      2'h2
`define EBD_M_LIT9      5'h19
`define EBD_M_LIT7      7'h63
`define EBD_M_PTROFS    7'h62
// Fixed opcode words, opcode fields and slot addresses.
`define EBD_OP_RETURN   14'h0008
`define EBD_OP_IRQ_EXIT 14'h0009
`define EBD_OP_ACC_CALL 14'h000a
`define EBD_OP_ACC_JUMP 14'h000b
`define EBD_OP_LIT_EXIT 6'h34
`define EBD_OP_ROTATE   4'hc
`define EBD_OP_DEC_SKIP 4'hb
`define EBD_OP_INC_SKIP 4'hf
`define EBD_SLOT0       7'h00
`define EBD_SLOT1       7'h01
`endif

// ### shared/ebd_pkg.sv
// Types shared by the instruction decoder and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package ebd_pkg;
    typedef enum logic [3:0] {
        EBD_FMT_BYTE   = 4'h0,
        EBD_FMT_BIT    = 4'h1,
        EBD_FMT_LIT8   = 4'h2,
        EBD_FMT_LIT11  = 4'h3,
        EBD_FMT_LIT7   = 4'h4,
        EBD_FMT_LIT5   = 4'h5,
        EBD_FMT_LIT9   = 4'h6,
        EBD_FMT_PTROFS = 4'h7,
        EBD_FMT_PTRINC = 4'h8,
        EBD_FMT_OPONLY = 4'h9
    } ebd_fmt_type;

    typedef struct packed {
        ebd_fmt_type fmt;
        logic [13:0] opcode;
        logic        dest_file;
        logic [6:0]  faddr;
        logic [2:0]  bitnum;
        logic [10:0] literal;
        logic        ptr_sel;
        logic [1:0]  ptr_mode;
        logic        is_rot;
        logic        uses_file;
    } ebd_dec_type;

    typedef enum logic [1:0] {
        EBD_ST_IDLE = 2'h0,
        EBD_ST_EXEC = 2'h1
    } ebd_state_type;
endpackage
